/* File: verilog/fault_timing_cfg.svh */
// constants for the port fault timing block
`ifndef FAULT_TIMING_CFG_SVH
`define FAULT_TIMING_CFG_SVH
`define CLK_HZ 10000000
`define MS_PER_S 1000
`define COOL_S 1
`define LIM_T0_MS 60
`define LIM_T1_MS 15
`define LIM_T2_MS 12
`define LIM_T3_MS 10
`define START_T0_MS 60
`define START_T1_MS 30
`define START_T2_MS 120
`define START_T3_MS 200
`define OVLD_T0_MS 60
`define OVLD_T1_MS 30
`define OVLD_T2_MS 120
`define OVLD_T3_MS 240
`define CNT_W 24
`define CNT_ONE 24'h000001
`define CNT_ZERO 24'h000000
`define PRE_ONE 4'h1
`define DEC_PRE_MAX 4'hf
`define IDX_W 8
`define IDX_LSB 2
`define IDX_NONE 8'hff
`define REG_TIMING_IDX 8'h16
`define REG_CTL_IDX 8'h20
`define REG_CMD_IDX 8'h21
`define REG_STAT_IDX 8'h22
`define REG_IRQ_ST_IDX 8'h23
`define REG_IRQ_MSK_IDX 8'h24
`define TIMING_RST 8'h00
`define LIM_FLD 7:6
`define START_FLD 5:4
`define OVLD_FLD 3:2
`define DISC_FLD 1:0
`define RS_LIM 0
`define RS_START 1
`define RS_OVLD 2
`define MODE_W 2
`define DETEN_LSB 8
`define CLSEN_LSB 12
`define CMD_ON_LSB 0
`define CMD_OFF_LSB 4
`define CMD_RST_LSB 8
`define ST_PWR_LSB 0
`define ST_COOL_LSB 4
`define ST_START_LSB 8
`define EV_LIM_LSB 0
`define EV_OVLD_LSB 4
`define EV_START_LSB 8
`define PIN_LIM_LSB 0
`define PIN_OVLD_LSB 4
`define PIN_DC_LSB 8
`define PIN_FAST 12
`define PIN_W 13
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* File: verilog/fault_timing_pkg.sv */
// types and helpers shared by the fault timing block
`include "fault_timing_cfg.svh"
package fault_timing_pkg;
  typedef logic [`CNT_W-1:0] cyc_t;
  typedef enum logic [1:0] {MODE_OFF, MODE_MANUAL, MODE_SEMI, MODE_AUTO}
    mode_e;
  typedef enum logic [1:0] {CH_OFF, CH_START, CH_ON} chan_e;
  typedef struct packed {
    chan_e st;
    logic pwr;
    logic cool;
    logic det_go;
    logic [3:0] pre;
    cyc_t start_cnt;
    cyc_t lim_cnt;
    cyc_t ovld_cnt;
    cyc_t cool_cnt;
  } chan_s;
  function automatic cyc_t ms2cyc(input int ms);
    return cyc_t'(ms * (`CLK_HZ / `MS_PER_S));
  endfunction
endpackage

/* File: verilog/reg_if.sv */
// register access path between the bus slave and the timing logic
`timescale 1ns/10ps
`include "fault_timing_cfg.svh"
interface reg_if;
  logic wr_en;
  logic [`IDX_W-1:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic rd_en;
  logic [`IDX_W-1:0] rd_idx;
  logic [31:0] rd_data;
  logic rd_hit;
  modport slave (output wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx,
                 input wr_hit, rd_data, rd_hit);
  modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx,
                output wr_hit, rd_data, rd_hit);
endinterface

/* File: verilog/axil_slave.sv */
// axi4-lite slave front end feeding the register path
`timescale 1ns/10ps
`include "fault_timing_cfg.svh"
module axil_slave #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  reg_if.slave rif
);
  import fault_timing_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_got;
    logic w_got;
    logic bvalid;
    logic rvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } slv_s;

  slv_s s_q, s_d;

  // out-of-range upper bits map to no register
  function automatic logic [`IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    if (|(a >> (`IDX_W + `IDX_LSB)))
      return `IDX_NONE;
    return a[`IDX_LSB +: `IDX_W];
  endfunction

  assign rif.wr_en = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign rif.wr_idx = idx_of(s_q.awaddr);
  assign rif.wr_data = s_q.wdata;
  assign rif.wr_strb = s_q.wstrb;
  assign rif.rd_en = arvalid && s_q.arready;
  assign rif.rd_idx = idx_of(araddr);

  always_comb begin
    s_d = s_q;
    if (awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (s_q.bvalid && bready)
      s_d.bvalid = 1'b0;
    if (rif.wr_en) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = rif.wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_q.rvalid && rready)
      s_d.rvalid = 1'b0;
    if (rif.rd_en) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rif.rd_hit ? rif.rd_data : 32'h00000000;
      s_d.rresp = rif.rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    // one write and one read in flight; readies drop until answered
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign arready = s_q.arready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
endmodule

/* File: verilog/port_fault_timing_config.sv */
// fault timing register and per-channel fault, start and cool-down timers
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "fault_timing_cfg.svh"
module port_fault_timing_config #(
  parameter int ADDR_W = 12,
  parameter fault_timing_pkg::cyc_t COOL_CYC =
    fault_timing_pkg::cyc_t'(`COOL_S * `CLK_HZ),
  parameter logic [3:0][`CNT_W-1:0] LIM_CYC = {
    fault_timing_pkg::ms2cyc(`LIM_T3_MS),
    fault_timing_pkg::ms2cyc(`LIM_T2_MS),
    fault_timing_pkg::ms2cyc(`LIM_T1_MS),
    fault_timing_pkg::ms2cyc(`LIM_T0_MS)},
  parameter logic [3:0][`CNT_W-1:0] START_CYC = {
    fault_timing_pkg::ms2cyc(`START_T3_MS),
    fault_timing_pkg::ms2cyc(`START_T2_MS),
    fault_timing_pkg::ms2cyc(`START_T1_MS),
    fault_timing_pkg::ms2cyc(`START_T0_MS)},
  parameter logic [3:0][`CNT_W-1:0] OVLD_CYC = {
    fault_timing_pkg::ms2cyc(`OVLD_T3_MS),
    fault_timing_pkg::ms2cyc(`OVLD_T2_MS),
    fault_timing_pkg::ms2cyc(`OVLD_T1_MS),
    fault_timing_pkg::ms2cyc(`OVLD_T0_MS)}
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [3:0] cur_at_limit,
  input wire logic [3:0] cur_over_ovld,
  input wire logic [3:0] dc_disconnect,
  input wire logic fast_shutdown_input,
  output logic [3:0] port_power_en,
  output logic [3:0] detect_start,
  output logic irq
);
  import fault_timing_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [`PIN_W-1:0] s1;
    logic [`PIN_W-1:0] s2;
    logic [7:0] timing;
    logic [15:0] ctl;
    logic [11:0] cmd;
    logic [2:0] restart;
    logic [11:0] irq_st;
    logic [11:0] irq_mask;
    logic irq;
    chan_s [3:0] ch;
  } top_s;

  top_s s_q, s_d;
  reg_if rif ();

  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] b);
    logic [15:0] r;
    r = old;
    if (b[0])
      r[7:0] = d[7:0];
    if (b[1])
      r[15:8] = d[15:8];
    return r;
  endfunction

  function automatic logic mapped(input logic [`IDX_W-1:0] idx);
    return idx == `REG_TIMING_IDX || idx == `REG_CTL_IDX ||
           idx == `REG_CMD_IDX || idx == `REG_STAT_IDX ||
           idx == `REG_IRQ_ST_IDX || idx == `REG_IRQ_MSK_IDX;
  endfunction

  axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .rif(rif.slave)
  );

  // ----------------------------------------
  // timeouts from the shared fields
  // ----------------------------------------
  cyc_t lim_tmo, start_tmo, ovld_tmo;
  assign lim_tmo = LIM_CYC[s_q.timing[`LIM_FLD]];
  assign start_tmo = START_CYC[s_q.timing[`START_FLD]];
  assign ovld_tmo = OVLD_CYC[s_q.timing[`OVLD_FLD]];

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [11:0] stat;
  always_comb begin
    stat = '0;
    for (int i = 0; i < 4; i++) begin
      stat[`ST_PWR_LSB + i] = s_q.ch[i].pwr;
      stat[`ST_COOL_LSB + i] = s_q.ch[i].cool;
      stat[`ST_START_LSB + i] = s_q.ch[i].st == CH_START;
    end
  end

  assign rif.wr_hit = mapped(rif.wr_idx);
  assign rif.rd_hit = mapped(rif.rd_idx);

  always_comb begin
    case (rif.rd_idx)
      `REG_TIMING_IDX: rif.rd_data = {24'h000000, s_q.timing};
      `REG_CTL_IDX: rif.rd_data = {16'h0000, s_q.ctl};
      `REG_STAT_IDX: rif.rd_data = {20'h00000, stat};
      `REG_IRQ_ST_IDX: rif.rd_data = {20'h00000, s_q.irq_st};
      `REG_IRQ_MSK_IDX: rif.rd_data = {20'h00000, s_q.irq_mask};
      default: rif.rd_data = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [15:0] w16;
    logic [11:0] clr;
    logic [11:0] ev;
    chan_s c;
    mode_e md;
    mode_e md_new;
    logic at_lim, over, dec, off_now, trip;
    s_d = s_q;
    w16 = '0;
    clr = '0;
    ev = '0;
    c = s_q.ch[0];
    md = MODE_OFF;
    md_new = MODE_OFF;
    at_lim = 1'b0;
    over = 1'b0;
    dec = 1'b0;
    off_now = 1'b0;
    trip = 1'b0;
    // pins are asynchronous to aclk
    s_d.s1 = {fast_shutdown_input, dc_disconnect, cur_over_ovld,
              cur_at_limit};
    s_d.s2 = s_q.s1;
    s_d.cmd = '0;
    s_d.restart = '0;

    if (rif.wr_en) begin
      case (rif.wr_idx)
        `REG_TIMING_IDX: begin
          w16 = wmerge({8'h00, s_q.timing}, rif.wr_data, rif.wr_strb);
          s_d.timing = w16[7:0];
          // a changed field restarts the running timer
          s_d.restart[`RS_LIM] = w16[`LIM_FLD] != s_q.timing[`LIM_FLD];
          s_d.restart[`RS_START] =
            w16[`START_FLD] != s_q.timing[`START_FLD];
          s_d.restart[`RS_OVLD] = w16[`OVLD_FLD] != s_q.timing[`OVLD_FLD];
        end
        `REG_CTL_IDX: begin
          s_d.ctl = wmerge(s_q.ctl, rif.wr_data, rif.wr_strb);
        end
        `REG_CMD_IDX: begin
          w16 = wmerge(16'h0000, rif.wr_data, rif.wr_strb);
          s_d.cmd = w16[11:0];
        end
        `REG_IRQ_ST_IDX: begin
          w16 = wmerge(16'h0000, rif.wr_data, rif.wr_strb);
          clr = w16[11:0];
        end
        `REG_IRQ_MSK_IDX: begin
          w16 = wmerge({4'h0, s_q.irq_mask}, rif.wr_data, rif.wr_strb);
          s_d.irq_mask = w16[11:0];
        end
        default: begin
        end
      endcase
    end

    for (int i = 0; i < 4; i++) begin
      c = s_q.ch[i];
      md = mode_e'(s_q.ctl[`MODE_W * i +: `MODE_W]);
      at_lim = s_q.s2[`PIN_LIM_LSB + i];
      over = s_q.s2[`PIN_OVLD_LSB + i];
      off_now = s_q.cmd[`CMD_OFF_LSB + i] || s_q.cmd[`CMD_RST_LSB + i] ||
                s_q.s2[`PIN_DC_LSB + i] || s_q.s2[`PIN_FAST] ||
                md == MODE_OFF;
      trip = 1'b0;
      c.det_go = 1'b0;
      // free-running divider sets the slow decrement rate
      c.pre = s_q.ch[i].pre + `PRE_ONE;
      dec = s_q.ch[i].pre == `DEC_PRE_MAX;

      if (c.cool) begin
        if (c.cool_cnt >= COOL_CYC - `CNT_ONE) begin
          c.cool = 1'b0;
          c.cool_cnt = `CNT_ZERO;
          c.det_go = md == MODE_SEMI && s_q.ctl[`DETEN_LSB + i] &&
                     s_q.ctl[`CLSEN_LSB + i];
        end else begin
          c.cool_cnt = c.cool_cnt + `CNT_ONE;
        end
      end
      // only a reset command or entering off or manual cancels; staying in manual keeps
      // the cool-down, else turn-on refusal would be void there
      md_new = mode_e'(s_d.ctl[`MODE_W * i +: `MODE_W]);
      if (s_q.cmd[`CMD_RST_LSB + i] || (md_new != md &&
          (md_new == MODE_OFF || md_new == MODE_MANUAL))) begin
        c.cool = 1'b0;
        c.cool_cnt = `CNT_ZERO;
        c.det_go = 1'b0;
      end

      unique case (c.st)
        CH_OFF: begin
          // no turn-on while cooling down
          if (s_q.cmd[`CMD_ON_LSB + i] && !c.cool && md != MODE_OFF) begin
            c.st = CH_START;
            c.pwr = 1'b1;
            c.start_cnt = `CNT_ZERO;
          end
        end
        CH_START: begin
          if (s_q.restart[`RS_START]) begin
            c.start_cnt = `CNT_ZERO;
          end else if (c.start_cnt >= start_tmo - `CNT_ONE) begin
            if (at_lim) begin
              trip = 1'b1;
              ev[`EV_START_LSB + i] = 1'b1;
            end else begin
              c.st = CH_ON;
            end
          end else begin
            c.start_cnt = c.start_cnt + `CNT_ONE;
          end
        end
        CH_ON: begin
          if (s_q.restart[`RS_LIM]) begin
            c.lim_cnt = `CNT_ZERO;
          end else if (at_lim) begin
            if (c.lim_cnt + `CNT_ONE >= lim_tmo) begin
              trip = 1'b1;
              ev[`EV_LIM_LSB + i] = 1'b1;
            end else begin
              c.lim_cnt = c.lim_cnt + `CNT_ONE;
            end
          end else if (dec && c.lim_cnt != `CNT_ZERO) begin
            c.lim_cnt = c.lim_cnt - `CNT_ONE;
          end
          if (s_q.restart[`RS_OVLD]) begin
            c.ovld_cnt = `CNT_ZERO;
          end else if (over) begin
            if (c.ovld_cnt + `CNT_ONE >= ovld_tmo) begin
              trip = 1'b1;
              ev[`EV_OVLD_LSB + i] = 1'b1;
            end else begin
              c.ovld_cnt = c.ovld_cnt + `CNT_ONE;
            end
          end else if (dec && c.ovld_cnt != `CNT_ZERO) begin
            c.ovld_cnt = c.ovld_cnt - `CNT_ONE;
          end
        end
        default: begin
          c.st = CH_OFF;
          c.pwr = 1'b0;
        end
      endcase

      if (trip) begin
        c.st = CH_OFF;
        c.pwr = 1'b0;
        c.cool = 1'b1;
        c.cool_cnt = `CNT_ZERO;
        c.start_cnt = `CNT_ZERO;
        c.lim_cnt = `CNT_ZERO;
        c.ovld_cnt = `CNT_ZERO;
      end
      // fast shutdown leaves a running cool-down alone
      if (off_now) begin
        c.st = CH_OFF;
        c.pwr = 1'b0;
        c.start_cnt = `CNT_ZERO;
        c.lim_cnt = `CNT_ZERO;
        c.ovld_cnt = `CNT_ZERO;
      end
      s_d.ch[i] = c;
    end

    // a new event wins over a clear in the same cycle
    s_d.irq_st = (s_q.irq_st & ~clr) | ev;
    s_d.irq = |(s_d.irq_st & s_d.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_out
    assign port_power_en[g] = s_q.ch[g].pwr;
    assign detect_start[g] = s_q.ch[g].det_go;
  end
  assign irq = s_q.irq;
endmodule

/* File: tb/port_fault_timing_config_props.sv */
// concurrent checks on the fault timing block ports
`timescale 1ns/10ps
module port_fault_timing_config_props #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic [3:0] cur_at_limit,
  input wire logic [3:0] cur_over_ovld,
  input wire logic [3:0] dc_disconnect,
  input wire logic fast_shutdown_input,
  input wire logic [3:0] port_power_en,
  input wire logic [3:0] detect_start,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  a_bresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address taken while answer pending");
  a_aw_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_b_timing: assert property (awvalid && awready && wvalid && wready
    |=> !bvalid ##1 bvalid) else $error("write response late");
  a_r_timing: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  // ----------------------------------------
  // channel power, detect start and irq
  // ----------------------------------------
  // two sync stages plus one edge to act
  a_fast_off: assert property (fast_shutdown_input [*3] |=> port_power_en == 4'h0)
    else $error("fast shutdown left a channel powered");
  a_dc_off: assert property (dc_disconnect[0] [*3] |=> !port_power_en[0])
    else $error("dc disconnect left channel powered");
  a_detect_pulse: assert property (detect_start != 4'h0 |=> detect_start == 4'h0)
    else $error("detect start longer than one cycle");
  c_detect: cover property (detect_start != 4'h0);
  c_irq: cover property ($rose(irq));
  c_fast: cover property ($fell(port_power_en[0]) && fast_shutdown_input);
endmodule

/* File: tb/pd_model.sv */
// powered device load model: draws limited current only while powered
`timescale 1ns/10ps
module pd_model (
  input wire logic aclk,
  input wire logic [3:0] port_power_en,
  input wire logic [3:0] lim_fault,
  input wire logic [3:0] ovld_fault,
  input wire logic [3:0] unplug,
  output logic [3:0] cur_at_limit,
  output logic [3:0] cur_over_ovld,
  output logic [3:0] dc_disconnect
);
  // an unpowered channel draws nothing, so no fault flag without power
  always_ff @(posedge aclk) begin
    cur_at_limit <= port_power_en & lim_fault;
    cur_over_ovld <= port_power_en & ovld_fault;
    dc_disconnect <= unplug;
  end
endmodule

/* File: tb/tb_port_fault_timing_config.sv */
// self-checking bench for the fault timing block
`timescale 1ns/10ps
module tb_port_fault_timing_config;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, fast_shutdown_input;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [3:0] wstrb, cur_at_limit, cur_over_ovld, dc_disconnect;
  logic [3:0] port_power_en, detect_start, lim_f, ovld_f, unplug;
  logic [1:0] bresp, rresp, resp_q;
  int error_cnt = 0;
  int n_tests = 0;
  port_fault_timing_config #(.COOL_CYC(24'd50),
    .LIM_CYC({24'd40, 24'd30, 24'd20, 24'd10}),
    .START_CYC({24'd40, 24'd30, 24'd20, 24'd10}),
    .OVLD_CYC({24'd40, 24'd30, 24'd20, 24'd10})) port_fault_timing_config_i (.*);
  pd_model pd_model_i (.aclk(aclk), .port_power_en(port_power_en),
    .lim_fault(lim_f), .ovld_fault(ovld_f), .unplug(unplug),
    .cur_at_limit(cur_at_limit), .cur_over_ovld(cur_over_ovld),
    .dc_disconnect(dc_disconnect));
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awvalid <= 1; wvalid <= 1; awaddr <= a; wdata <= d; wstrb <= 4'hf;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_ok = 1; awvalid <= 0; end
      if (wvalid && wready) begin w_ok = 1; wvalid <= 0; end
    end
    bready <= 1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp_q = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    arvalid <= 1; araddr <= a;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0; rready <= 1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_q = rdata; resp_q = rresp;
    rready <= 0;
  endtask
  task automatic wait_pwr(input int ch, input logic v, input int lim);
    for (int i = 0; i < lim && port_power_en[ch] !== v; i++) @(posedge aclk);
    chk(32'(port_power_en[ch]), 32'(v));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(12'h058); chk(rd_q, 32'h0);
    wr(12'h058, 32'h1e5); rd(12'h058); chk(rd_q, 32'he5);
    wr(12'h058, 32'h0);
    wr(12'h3fc, 32'h1); chk(32'(resp_q), 32'h2);
    rd(12'h3fc); chk(rd_q, 32'h0); chk(32'(resp_q), 32'h2);
  endtask
  task automatic t_lim();
    wr(12'h080, 32'h1); wr(12'h090, 32'h1); wr(12'h084, 32'h1);
    wait_pwr(0, 1, 5);
    repeat (15) @(posedge aclk);
    lim_f <= 4'h1;
    repeat (6) @(posedge aclk);
    chk(32'(port_power_en[0]), 32'h1);
    wait_pwr(0, 0, 10);
    @(posedge aclk); chk(32'(irq), 32'h1);
    rd(12'h088); chk(rd_q, 32'h10);
    wr(12'h084, 32'h1); repeat (3) @(posedge aclk);
    chk(32'(port_power_en[0]), 32'h0);
    wr(12'h08c, 32'h1); @(posedge aclk); chk(32'(irq), 32'h0);
    lim_f <= 4'h0;
  endtask
  task automatic t_start();
    lim_f <= 4'h2;
    wr(12'h080, 32'h5); wr(12'h084, 32'h2);
    wait_pwr(1, 1, 5);
    repeat (5) @(posedge aclk); chk(32'(port_power_en[1]), 32'h1);
    wait_pwr(1, 0, 12);
    rd(12'h088); chk(rd_q[7:4], 32'h2);
    chk(32'(irq), 32'h0);
    wr(12'h084, 32'h200); rd(12'h088); chk(rd_q[7:4], 32'h0);
    lim_f <= 4'h0;
    wr(12'h084, 32'h2); wait_pwr(1, 1, 5);
    wr(12'h084, 32'h20); wait_pwr(1, 0, 5);
    wr(12'h08c, 32'hfff);
  endtask
  task automatic t_semi();
    int i;
    lim_f <= 4'h4;
    wr(12'h080, 32'h4425); wr(12'h084, 32'h4);
    wait_pwr(2, 1, 5);
    wait_pwr(2, 0, 30);
    lim_f <= 4'h0;
    for (i = 0; i < 80 && detect_start[2] !== 1'b1; i++) @(posedge aclk);
    chk(32'(detect_start), 32'h4);
  endtask
  task automatic t_off();
    wr(12'h084, 32'h1); wait_pwr(0, 1, 5);
    fast_shutdown_input <= 1; wait_pwr(0, 0, 6);
    fast_shutdown_input <= 0;
    repeat (3) @(posedge aclk);
    wr(12'h084, 32'h1); wait_pwr(0, 1, 5);
    unplug <= 4'h1; wait_pwr(0, 0, 6);
    unplug <= 4'h0;
  endtask
  task automatic t_ovld();
    repeat (3) @(posedge aclk);
    wr(12'h084, 32'h1); wait_pwr(0, 1, 5);
    repeat (12) @(posedge aclk);
    ovld_f <= 4'h1;
    repeat (8) @(posedge aclk);
    chk(32'(port_power_en[0]), 32'h1);
    wait_pwr(0, 0, 10);
    rd(12'h08c); chk(rd_q[7:4], 32'h1);
    ovld_f <= 4'h0;
  endtask
  initial begin
    aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
    rready = 0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
    fast_shutdown_input = 0; lim_f = 0; ovld_f = 0; unplug = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_lim();
    repeat (60) @(posedge aclk);
    t_start();
    t_semi();
    t_off();
    t_ovld();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    conclude();
  end
endmodule
bind port_fault_timing_config port_fault_timing_config_props #(.ADDR_W(ADDR_W))
  props_i (.*);
